// ---- verilog/ckg_consts.svh ----
// constants of the clock guard and reset sequencer
`ifndef CKG_CONSTS_SVH
`define CKG_CONSTS_SVH
`define CKG_CTRL_IDX 10'h0d1
`define CKG_STAT_IDX 10'h0d2
`define CKG_CTRL_RESET 8'h40
`define CKG_OSC_OFF_BIT 2
`define CKG_SHORT_DELAY 16'h0800
`define CKG_LONG_DELAY 16'h8000
`define CKG_FETCH_LAST 1'h1
`define CKG_RESET_VECTOR 12'hffe
`define CKG_TMR_DIV 4'hc
`define CKG_CPU_DIV 4'hd
`define CKG_GUARD_MIN 4'h3
`define CKG_MISS_CYC 8'h10
`define CKG_WDOG_PULSE 3'h4
`endif

// ---- verilog/ckg_pkg.sv ----
// types of the clock guard and reset sequencer
package ckg_pkg;
   typedef enum logic [1:0] {
      CKG_RUN,
      CKG_HOLD,
      CKG_DELAY,
      CKG_FETCH
   } ckg_state_t;

   typedef struct packed {
      logic in_reset;
      logic stack_clear;
      logic vector_fetch;
      logic pc_load;
      logic pullup_inputs;
      logic nmi_mode;
   } ckg_core_t;
endpackage

// ---- verilog/ckg_top.sv ----
// clock guard, backup oscillator switch-over and reset sequencer
//
// Overview of operation
// - guard drops clock edges above maximum rate
// - backup oscillator only with guard option
// - backup starts one period after missing edge
// - backup clock drives core like main clock
// - power-on delay counted on backup until main
// - backup stops once main oscillator runs
// - control bit 2 stops main, guard only
// - other control bits feed the converter
// - low supply holds static reset when enabled
// - low supply reset drives reset pin low
// - pin, watchdog and low supply reset
// - delay 2048 or 32768, then 2-cycle fetch
// - reset clears stack, loads vector 0ffe
// - reset enters nmi mode until return
// - pin low extended by full internal delay
// - hold reset while pin low, then delay
// - pin reset: halt, pull-up inputs, restart osc
// - pin reset in stop: start osc, pull-ups
// - watchdog end-of-count restarts as pin reset
// - watchdog pulses reset pin only briefly
// - divide internal clock by 12 and 13
//
// Local design decision: register access over APB.
`include "ckg_consts.svh"
`timescale 1ns/10ps
module ckg_top
#(
   parameter logic [15:0] LONG_DELAY = `CKG_LONG_DELAY,
   parameter logic [7:0] MISS_CYC = `CKG_MISS_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic main_osc_in,
   input wire logic backup_osc_in,
   input wire logic clock_guard_option,
   input wire logic low_voltage_detector_option,
   input wire logic long_delay_option,
   input wire logic reset_pin_in,
   input wire logic wdog_eoc,
   input wire logic low_supply,
   input wire logic stop_mode,
   input wire logic return_from_interrupt_instr,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic main_osc_enable,
   output logic backup_osc_enable,
   output logic int_clk_tick,
   output logic timer_tick,
   output logic cpu_tick,
   output logic osc_restart,
   output ckg_pkg::ckg_core_t core,
   output logic [11:0] pc_value,
   output logic [6:0] converter_ctrl
);
   import ckg_pkg::*;

   // ********************************************************
   // signals
   // ********************************************************
   ckg_state_t state_q;
   logic pin_s1_q;
   logic pin_s2_q;
   logic lv_s1_q;
   logic lv_s2_q;
   logic main_q;
   logic main_qq;
   logic back_q;
   logic back_qq;
   logic main_edge;
   logic back_edge;
   logic [7:0] miss_cnt_q;
   logic main_running_q;
   logic backup_on_q;
   logic sel_backup_q;
   logic raw_edge;
   logic [3:0] guard_cnt_q;
   logic tick;
   logic [3:0] div12_q;
   logic [3:0] div13_q;
   logic [15:0] cnt_q;
   logic [15:0] delay_last;
   logic hold_src;
   logic lv_active;
   logic [2:0] wd_cnt_q;
   logic [7:0] ctrl_q;
   logic guard_stop;
   logic wr_en;
   logic hit_ctrl;
   logic hit_stat;

   // ********************************************************
   // input synchronisers
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
         lv_s1_q <= 1'b0;
         lv_s2_q <= 1'b0;
      end
      else
      begin
         pin_s1_q <= reset_pin_in;
         pin_s2_q <= pin_s1_q;
         lv_s1_q <= low_supply;
         lv_s2_q <= lv_s1_q;
      end
   end

   // ********************************************************
   // oscillator edge detection
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_q <= 1'b0;
         main_qq <= 1'b0;
         back_q <= 1'b0;
         back_qq <= 1'b0;
      end
      else
      begin
         main_q <= main_osc_in;
         main_qq <= main_q;
         back_q <= backup_osc_in;
         back_qq <= back_q;
      end
   end

   assign main_edge = main_q & ~main_qq;
   assign back_edge = back_q & ~back_qq;

   // ********************************************************
   // missing edge watch and backup oscillator control
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         miss_cnt_q <= 8'h00;
         main_running_q <= 1'b0;
      end
      else if (main_edge)
      begin
         miss_cnt_q <= 8'h00;
         main_running_q <= 1'b1;
      end
      else if (miss_cnt_q != MISS_CYC)
      begin
         miss_cnt_q <= miss_cnt_q + 8'h01;
      end
      else
      begin
         main_running_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         backup_on_q <= 1'b0;
      end
      else
      begin
         // only with the guard, and only while main is absent
         backup_on_q <= clock_guard_option & ~main_running_q;
      end
   end

   // source changes on an edge of the new source, or back to main at once without the guard option
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_backup_q <= 1'b0;
      end
      else if (!clock_guard_option || main_edge)
      begin
         sel_backup_q <= 1'b0;
      end
      else if (backup_on_q && back_edge)
      begin
         sel_backup_q <= 1'b1;
      end
   end

   // ********************************************************
   // internal clock and guard filter
   // ********************************************************
   assign raw_edge = sel_backup_q ? back_edge : main_edge;
   assign tick = raw_edge &
                 (~clock_guard_option ||
                  guard_cnt_q >= `CKG_GUARD_MIN);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         guard_cnt_q <= 4'h0;
      end
      else if (tick)
      begin
         guard_cnt_q <= 4'h1;
      end
      else if (guard_cnt_q < `CKG_GUARD_MIN)
      begin
         guard_cnt_q <= guard_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_clk_tick <= 1'b0;
      end
      else
      begin
         int_clk_tick <= tick;
      end
   end

   // ********************************************************
   // dividers for timer and cpu cycle
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div12_q <= 4'h0;
         timer_tick <= 1'b0;
      end
      else
      begin
         timer_tick <= tick && (div12_q == `CKG_TMR_DIV - 4'h1);
         if (tick)
         begin
            div12_q <= (div12_q == `CKG_TMR_DIV - 4'h1) ? 4'h0 :
                       div12_q + 4'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div13_q <= 4'h0;
         cpu_tick <= 1'b0;
      end
      else
      begin
         cpu_tick <= tick && (div13_q == `CKG_CPU_DIV - 4'h1);
         if (tick)
         begin
            div13_q <= (div13_q == `CKG_CPU_DIV - 4'h1) ? 4'h0 :
                       div13_q + 4'h1;
         end
      end
   end

   // ********************************************************
   // reset sequencer
   // ********************************************************
   assign lv_active = low_voltage_detector_option & lv_s2_q;
   assign hold_src = ~pin_s2_q | lv_active;
   assign delay_last = (long_delay_option ? LONG_DELAY :
                        `CKG_SHORT_DELAY) - 16'h0001;

   // power-on starts in the delay, counted on whichever clock ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= CKG_DELAY;
         cnt_q <= 16'h0000;
      end
      else if (hold_src)
      begin
         state_q <= CKG_HOLD;
         cnt_q <= 16'h0000;
      end
      else
      begin
         case (state_q)
            CKG_HOLD:
            begin
               state_q <= CKG_DELAY;
               cnt_q <= 16'h0000;
            end
            CKG_DELAY:
            begin
               if (tick && cnt_q == delay_last)
               begin
                  state_q <= CKG_FETCH;
                  cnt_q <= 16'h0000;
               end
               else if (tick)
               begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            CKG_FETCH:
            begin
               if (tick && cnt_q[0] == `CKG_FETCH_LAST)
               begin
                  state_q <= CKG_RUN;
                  cnt_q <= 16'h0000;
               end
               else if (tick)
               begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            CKG_RUN:
            begin
               if (wdog_eoc)
               begin
                  state_q <= CKG_DELAY;
                  cnt_q <= 16'h0000;
               end
            end
            default:
            begin
               state_q <= CKG_DELAY;
               cnt_q <= 16'h0000;
            end
         endcase
      end
   end

   // ********************************************************
   // reset pin drive
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wd_cnt_q <= 3'h0;
      end
      else if (state_q == CKG_RUN && wdog_eoc && !hold_src)
      begin
         wd_cnt_q <= `CKG_WDOG_PULSE;
      end
      else if (wd_cnt_q != 3'h0)
      begin
         wd_cnt_q <= wd_cnt_q - 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_pin_oe <= 1'b0;
         reset_pin_out <= 1'b0;
      end
      else
      begin
         reset_pin_oe <= lv_active || wd_cnt_q != 3'h0;
         reset_pin_out <= 1'b0;
      end
   end

   // ********************************************************
   // core side outputs
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core <= '0;
         pc_value <= `CKG_RESET_VECTOR;
         osc_restart <= 1'b0;
      end
      else
      begin
         core.in_reset <= state_q != CKG_RUN;
         core.stack_clear <= state_q != CKG_RUN;
         core.vector_fetch <= state_q == CKG_FETCH;
         core.pc_load <= state_q == CKG_FETCH && tick &&
                         cnt_q[0] == `CKG_FETCH_LAST;
         core.pullup_inputs <= state_q == CKG_HOLD ||
                               state_q == CKG_DELAY;
         if (state_q != CKG_RUN)
         begin
            core.nmi_mode <= 1'b1;
         end
         else if (return_from_interrupt_instr)
         begin
            core.nmi_mode <= 1'b0;
         end
         pc_value <= `CKG_RESET_VECTOR;
         // stop mode or a stopped oscillator is woken by reset
         osc_restart <= state_q == CKG_HOLD &&
                        (stop_mode || ctrl_q[`CKG_OSC_OFF_BIT]);
      end
   end

   assign guard_stop = clock_guard_option & ctrl_q[`CKG_OSC_OFF_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_osc_enable <= 1'b1;
         backup_osc_enable <= 1'b0;
      end
      else
      begin
         main_osc_enable <= ~guard_stop || state_q != CKG_RUN;
         backup_osc_enable <= backup_on_q;
      end
   end

   // ********************************************************
   // apb slave
   // ********************************************************
   assign hit_ctrl = paddr == {`CKG_CTRL_IDX, 2'b00};
   assign hit_stat = paddr == {`CKG_STAT_IDX, 2'b00};
   assign wr_en = psel & penable & pready & pwrite & hit_ctrl;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= `CKG_CTRL_RESET;
      end
      else if (state_q != CKG_RUN)
      begin
         ctrl_q <= `CKG_CTRL_RESET;
      end
      else if (wr_en)
      begin
         ctrl_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         converter_ctrl <= 7'h00;
      end
      else
      begin
         converter_ctrl <= {ctrl_q[7:3], ctrl_q[1:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_ctrl &
                    ~(hit_stat & ~pwrite);
         if (psel && !penable && !pwrite && hit_ctrl)
         begin
            prdata <= {24'h00_0000, ctrl_q};
         end
         else if (psel && !penable && !pwrite && hit_stat)
         begin
            prdata <= {26'h000_0000, core.nmi_mode,
                       state_q != CKG_RUN, sel_backup_q,
                       main_running_q, backup_on_q, lv_active};
         end
         else if (psel && !penable)
         begin
            prdata <= 32'h0000_0000;
         end
      end
   end
endmodule

// ---- test/ckg_monitor.sv ----
// assertions on the ports of the clock guard and reset sequencer
`timescale 1ns/10ps
module ckg_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clock_guard_option,
   input wire logic low_voltage_detector_option,
   input wire logic reset_pin_in,
   input wire logic wdog_eoc,
   input wire logic low_supply,
   input wire logic return_from_interrupt_instr,
   input wire logic reset_pin_oe,
   input wire logic main_osc_enable,
   input wire logic backup_osc_enable,
   input wire logic int_clk_tick,
   input wire ckg_pkg::ckg_core_t core,
   input wire logic [11:0] pc_value
);
   import ckg_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_quiet;
      !int_clk_tick ##1 !int_clk_tick;
   endsequence
   sequence s_pin_pulse;
      reset_pin_oe [*4] ##1 !reset_pin_oe;
   endsequence
   a_pc_vector: assert property (pc_value == 12'hffe)
      else $error("pc value is not the reset vector");
   a_guard_gap: assert property (clock_guard_option && int_clk_tick |=> s_quiet)
      else $error("guarded ticks too close");
   a_guard_off: assert property (!clock_guard_option [*3] |->
      main_osc_enable && !backup_osc_enable)
      else $error("oscillator control without guard");
   a_lvd_hold: assert property ((low_voltage_detector_option && low_supply) [*6]
      |-> core.in_reset && reset_pin_oe)
      else $error("low supply not holding reset");
   a_pin_hold: assert property (!reset_pin_in [*6]
      |-> core.in_reset && core.pullup_inputs)
      else $error("pin low not holding reset");
   a_wdog_pulse: assert property (wdog_eoc && !core.in_reset && reset_pin_in
      && !low_supply |-> ##2 s_pin_pulse)
      else $error("watchdog pin pulse wrong");
   a_fetch_load: assert property (core.pc_load |-> $past(core.vector_fetch))
      else $error("vector load without fetch");
   a_nmi_set: assert property ($rose(core.nmi_mode) |-> core.in_reset)
      else $error("nmi mode set outside reset");
   a_nmi_keep: assert property (core.nmi_mode &&
      !return_from_interrupt_instr |=> core.nmi_mode)
      else $error("nmi mode left without return");
endmodule

// ---- test/ckg_board.sv ----
// board model: main and backup oscillators, reset pin with pull-up
`timescale 1ns/10ps
module ckg_board
(
   input wire logic pclk,
   input wire logic main_en,
   input wire logic backup_en,
   input wire logic fast,
   input wire logic dev_oe,
   input wire logic board_rst_n,
   output logic main_osc,
   output logic backup_osc,
   output logic pin
);
   logic [2:0] div_q;
   initial
   begin
      div_q = 3'h0;
      main_osc = 1'b0;
      backup_osc = 1'b0;
   end
   // stopped oscillators stand still
   always @(posedge pclk)
   begin
      div_q <= div_q + 3'h1;
      if (main_en && (fast || div_q[0]))
         main_osc <= ~main_osc;
      if (backup_en && div_q == 3'h7)
         backup_osc <= ~backup_osc;
   end
   // open drain line, pulled up
   assign pin = board_rst_n & ~dev_oe;
endmodule

// ---- test/test_ckg_top.sv ----
// self-checking testbench of the clock guard and reset sequencer
`timescale 1ns/10ps
module test_ckg_top;
   import ckg_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fast;
   logic [11:0] paddr, pc_value;
   logic [31:0] pwdata, prdata, rd, v;
   logic main_osc_in, backup_osc_in, clock_guard_option, reset_pin_in;
   logic low_voltage_detector_option, long_delay_option, wdog_eoc;
   logic low_supply, stop_mode, return_from_interrupt_instr, reset_pin_out;
   logic reset_pin_oe, main_osc_enable, backup_osc_enable, int_clk_tick;
   logic timer_tick, cpu_tick, osc_restart, board_rst_n;
   logic [6:0] converter_ctrl;
   ckg_core_t core;
   int error_cnt, n_compared, seed, i, nt, ntm, ncp, a, b, c;
   ckg_top #(.LONG_DELAY(16'd64), .MISS_CYC(8'h10)) ckg_top_inst (.pclk,
      .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .main_osc_in, .backup_osc_in, .clock_guard_option,
      .low_voltage_detector_option, .long_delay_option, .reset_pin_in,
      .wdog_eoc, .low_supply, .stop_mode, .return_from_interrupt_instr,
      .reset_pin_out, .reset_pin_oe, .main_osc_enable, .backup_osc_enable,
      .int_clk_tick, .timer_tick, .cpu_tick, .osc_restart, .core, .pc_value,
      .converter_ctrl);
   ckg_board ckg_board_inst (.pclk, .main_en(main_osc_enable),
      .backup_en(backup_osc_enable), .fast, .dev_oe(reset_pin_oe),
      .board_rst_n, .main_osc(main_osc_in), .backup_osc(backup_osc_in),
      .pin(reset_pin_in));
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      nt <= nt + (int_clk_tick === 1'b1);
      ntm <= ntm + (timer_tick === 1'b1);
      ncp <= ncp + (cpu_tick === 1'b1);
   end
   // pulse count p times divisor d within one divisor of ticks t
   function automatic logic near(int t, int p, int d);
      return p * d <= t + d && p * d + d >= t;
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         error_cnt++;
         $display("FAIL %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, ad, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
      chk("apb_wait", k, 1);
   endtask
   // follows a reset to run, then leaves nmi mode
   task automatic seq(input int n);
      int d, f, k;
      {d, f, k} = 96'h0;
      repeat (3) @(posedge pclk);
      while (core.in_reset !== 1'b0 && k < 20000)
      begin
         @(posedge pclk);
         k++;
         if (int_clk_tick === 1'b1 && core.vector_fetch === 1'b1)
            f++;
         else if (int_clk_tick === 1'b1)
            d++;
      end
      chk("delay_ticks", d >= n - 2 && d <= n + 8, 1);
      chk("fetch_ticks", f >= 1 && f <= 2, 1);
      chk("nmi_set", core.nmi_mode, 1);
      @(posedge pclk);
      return_from_interrupt_instr <= 1'b1;
      @(posedge pclk);
      return_from_interrupt_instr <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("nmi_clear", core.nmi_mode, 0);
      chk("vector", pc_value, 12'hffe);
   endtask
   initial
   begin
      seed = 91;
      {presetn, psel, penable, pwrite, wdog_eoc, low_supply, fast} = 7'h0;
      {stop_mode, return_from_interrupt_instr, paddr, pwdata} = 46'h0;
      {clock_guard_option, low_voltage_detector_option} = 2'h3;
      {long_delay_option, board_rst_n} = 2'h3;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      seq(64);
      $display("test power_on done");
      apb(1'b0, 12'h344, 32'h0);
      chk("ctrl_reset", rd, 32'h40);
      for (i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 32'hfb : $random(seed) & 32'hfb;
         apb(1'b1, 12'h344, v);
         apb(1'b0, 12'h344, 32'h0);
         chk("ctrl_rw", rd, v);
         chk("converter", converter_ctrl, {v[7:3], v[1:0]});
      end
      apb(1'b0, 12'h3fc, 32'h0);
      chk("unmapped_err", err, 1);
      apb(1'b1, 12'h348, 32'h1);
      chk("status_ro_err", err, 1);
      apb(1'b0, 12'h348, 32'h0);
      chk("status", rd, 32'h4);
      chk("status_err", err, 0);
      $display("test registers done");
      apb(1'b1, 12'h344, 32'h4);
      repeat (60) @(posedge pclk);
      chk("main_stop", main_osc_enable, 0);
      chk("backup_start", backup_osc_enable, 1);
      a = nt;
      repeat (320) @(posedge pclk);
      chk("backup_ticks", near(nt - a, 20, 1), 1);
      apb(1'b1, 12'h344, 32'h0);
      repeat (20) @(posedge pclk);
      chk("main_run", main_osc_enable, 1);
      chk("backup_stop", backup_osc_enable, 0);
      {a, b, c} = {nt, ntm, ncp};
      repeat (1560) @(posedge pclk);
      chk("timer_div", near(nt - a, ntm - b, 12), 1);
      chk("cpu_div", near(nt - a, ncp - c, 13), 1);
      $display("test oscillators done");
      {clock_guard_option, fast} <= 2'h1;
      apb(1'b1, 12'h344, 32'h4);
      a = nt;
      repeat (300) @(posedge pclk);
      chk("no_stop", main_osc_enable, 1);
      chk("no_backup", backup_osc_enable, 0);
      chk("unguarded", near(nt - a, 150, 1), 1);
      apb(1'b1, 12'h344, 32'h0);
      clock_guard_option <= 1'b1;
      a = nt;
      repeat (300) @(posedge pclk);
      chk("guarded", nt - a <= 100 && nt - a >= 50, 1);
      {fast, long_delay_option} <= 2'h0;
      $display("test guard done");
      @(posedge pclk);
      wdog_eoc <= 1'b1;
      @(posedge pclk);
      wdog_eoc <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("wdog_reset", core.in_reset, 1);
      seq(2048);
      {stop_mode, board_rst_n} <= 2'h2;
      repeat (6) @(posedge pclk);
      chk("osc_restart", osc_restart, 1);
      chk("pullups", core.pullup_inputs, 1);
      {stop_mode, board_rst_n} <= 2'h1;
      seq(2048);
      low_supply <= 1'b1;
      repeat (200) @(posedge pclk);
      chk("lvd_reset", core.in_reset, 1);
      chk("lvd_pin", reset_pin_oe, 1);
      chk("lvd_pin_low", reset_pin_out, 0);
      chk("stack_clear", core.stack_clear, 1);
      low_supply <= 1'b0;
      seq(2048);
      $display("test resets done");
      summarize;
   end
   initial
   begin
      #1500000;
      error_cnt++;
      $display("FAIL run_time exp done got hang");
      summarize;
   end
endmodule
bind ckg_top ckg_monitor ckg_monitor_inst (.pclk, .presetn,
   .clock_guard_option, .low_voltage_detector_option, .reset_pin_in,
   .wdog_eoc, .low_supply, .return_from_interrupt_instr, .reset_pin_oe,
   .main_osc_enable, .backup_osc_enable, .int_clk_tick, .core, .pc_value);
